// ===== hdl/gpio_pin_config_group.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pin_config_consts.svh"

module gpio_pin_config_group #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              main_power_on_reset,
    input  wire logic              pci_reset_n,
    input  wire logic [7:0]        pad_in,
    output logic      [7:0]        pad_out,
    output logic      [7:0]        pad_oe,
    input  wire logic              fan_speed_out_a,
    input  wire logic              infrared_transmit_b,
    input  wire logic              keyboard_reset_out_n,
    input  wire logic              gate_a20_out,
    input  wire logic              drive_density_sel_zero,
    input  wire logic              drive_density_sel_one,
    input  wire logic              power_event_out_n,
    output logic                   infrared_receive_b,
    output logic                   edge_irq_b
);

    localparam int IDX_W = ADDR_W - 2;

    // the index occupies paddr above the two byte bits; the highest
    // index in use needs seven index bits, but the check asks for ten paddr bits
    if (ADDR_W < 10) begin : g_addr_w_check
        $error("ADDR_W too small for the register indices");
    end

    // routing, masks and reset values are written for exactly eight pins
    if (`NUM_PINS != 8) begin : g_pin_count_check
        $error("pin count must match the eight routed functions");
    end

    // the configuration words must be one contiguous run of indices
    if (`POWER_EVENT_IDX - `FAN_OUT_A_IDX + 1 != `NUM_PINS) begin : g_cfg_span_check
        $error("configuration indices do not cover every pin");
    end

    gpio_pin_config_pkg::cfg_t  cfg_r [0:`NUM_PINS-1];
    logic [7:0]                 data_r;
    logic [7:0]                 pad_meta_r;
    logic [7:0]                 pad_sync_r;
    logic                       main_meta_r;
    logic                       main_sync_r;
    logic                       pci_meta_r;
    logic                       pci_sync_r;
    logic                       irq_level_prev_r;
    logic [31:0]                prdata_r;
    logic                       pready_r;
    logic                       pslverr_r;
    logic [7:0]                 pad_out_r;
    logic [7:0]                 pad_oe_r;
    logic                       ir_rx_r;
    logic                       edge_irq_r;

    logic [7:0]                 pad_out_nxt;
    logic [7:0]                 pad_oe_nxt;
    logic [7:0]                 pin_level;
    logic [7:0]                 alt_out_sel;
    logic [7:0]                 alt_val;
    logic [7:0]                 drive_val;
    logic [IDX_W-1:0]           idx;
    logic                       access;
    logic                       wr_en;
    logic                       hit_cfg;
    logic                       hit_data;
    logic                       hit_level;
    logic [31:0]                prdata_nxt;
    logic                       main_reset;
    gpio_pin_config_pkg::fsel_t fsel_two;
    logic [7:0]                 cfg_sel;

    // standby reset value of each configuration register
    function automatic gpio_pin_config_pkg::cfg_t standby_default(input int pin);
        gpio_pin_config_pkg::cfg_t v;
        v = `CFG_RST_DEFAULT;
        if (pin == `PIN_IR_RX) begin
            v = `IR_RECEIVE_B_RST;
        end else if (pin == `PIN_IR_TX) begin
            v = `IR_TRANSMIT_B_RST;
        end
        return v;
    endfunction : standby_default

    // writable bits of each configuration register
    function automatic gpio_pin_config_pkg::cfg_t write_mask(input int pin);
        gpio_pin_config_pkg::cfg_t m;
        m = `CFG_MASK_ONE;
        if (pin == `PIN_DENSITY_ONE) begin
            m = `CFG_MASK_TWO;
        end
        return m;
    endfunction : write_mask

    // apb decode; a request is served when pready_r is high
    assign idx       = paddr[ADDR_W-1:2];
    assign access    = psel & penable;
    assign hit_cfg   = (idx >= IDX_W'(`FAN_OUT_A_IDX)) && (idx <= IDX_W'(`POWER_EVENT_IDX));
    assign hit_data  = (idx == IDX_W'(`PIN_DATA_IDX));
    assign hit_level = (idx == IDX_W'(`PIN_LEVEL_IDX));
    assign wr_en     = access & pready_r & pwrite;
    assign main_reset = main_sync_r | ~pci_sync_r;
    assign fsel_two  = cfg_r[`PIN_DENSITY_ONE][`CFG_FSEL_HI_BIT:`CFG_FSEL_BIT];

    // one-hot select of the configuration word addressed by this request
    genvar s;
    for (s = 0; s < `NUM_PINS; s++) begin : g_cfg_sel
        assign cfg_sel[s] = (idx == IDX_W'(`FAN_OUT_A_IDX + s));
    end

    // two-stage synchronisers for the pad levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_meta_r <= 8'h00;
            pad_sync_r <= 8'h00;
        end else begin
            pad_meta_r <= pad_in;
            pad_sync_r <= pad_meta_r;
        end
    end

    // two-stage synchronisers for the main supply and bus resets;
    // inactive after standby reset, so only a real main or bus reset reloads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_meta_r <= 1'b0;
            main_sync_r <= 1'b0;
            pci_meta_r  <= 1'b1;
            pci_sync_r  <= 1'b1;
        end else begin
            main_meta_r <= main_power_on_reset;
            main_sync_r <= main_meta_r;
            pci_meta_r  <= pci_reset_n;
            pci_sync_r  <= pci_meta_r;
        end
    end

    // configuration registers: standby reset, main reset reload, writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `NUM_PINS; i++) begin
                cfg_r[i] <= standby_default(i);
            end
        end else begin
            for (int i = 0; i < `NUM_PINS; i++) begin
                if (wr_en && cfg_sel[i]) begin
                    cfg_r[i] <= pwdata[7:0] & write_mask(i);
                end
            end
            // a main or bus reset wins over a write in the same cycle
            if (main_reset) begin
                cfg_r[`PIN_FAN]   <= `FAN_OUT_A_RST_MAIN;
                cfg_r[`PIN_IR_TX] <= `IR_TRANSMIT_B_RST;
            end
        end
    end

    // output data for pins in plain gpio use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r <= `PIN_DATA_RST;
        end else if (wr_en && hit_data) begin
            data_r <= pwdata[7:0];
        end
    end

    // alternate function routing for each pin
    always_comb begin
        alt_out_sel = 8'h00;
        alt_val     = 8'h00;
        // single-bit selects hand the pin to its dedicated output function
        alt_out_sel[`PIN_FAN]          = cfg_r[`PIN_FAN][`CFG_FSEL_BIT];
        alt_val[`PIN_FAN]              = fan_speed_out_a;
        alt_out_sel[`PIN_IR_TX]        = cfg_r[`PIN_IR_TX][`CFG_FSEL_BIT];
        alt_val[`PIN_IR_TX]            = infrared_transmit_b;
        alt_out_sel[`PIN_KBD_RST]      = cfg_r[`PIN_KBD_RST][`CFG_FSEL_BIT];
        alt_val[`PIN_KBD_RST]          = keyboard_reset_out_n;
        alt_out_sel[`PIN_GATE_A20]     = cfg_r[`PIN_GATE_A20][`CFG_FSEL_BIT];
        alt_val[`PIN_GATE_A20]         = gate_a20_out;
        alt_out_sel[`PIN_DENSITY_ZERO] = cfg_r[`PIN_DENSITY_ZERO][`CFG_FSEL_BIT];
        alt_val[`PIN_DENSITY_ZERO]     = drive_density_sel_zero;
        // two-bit select: only the density code routes an output
        alt_out_sel[`PIN_DENSITY_ONE]  = (fsel_two == `FSEL2_DENSITY);
        alt_val[`PIN_DENSITY_ONE]      = drive_density_sel_one;
        // low level from the event source reaches the pad, inverted only when the polarity bit is set
        alt_out_sel[`PIN_POWER_EVENT]  = cfg_r[`PIN_POWER_EVENT][`CFG_FSEL_BIT];
        alt_val[`PIN_POWER_EVENT]      = power_event_out_n;
    end

    // polarity, direction and driver style per pin
    genvar g;
    generate
        for (g = 0; g < `NUM_PINS; g++) begin : g_pin
            logic oe_pin;
            logic out_pin;

            // pad level seen by logic, after optional inversion
            assign pin_level[g] = pad_sync_r[g] ^ cfg_r[g][`CFG_POL_BIT];
            // value heading for the pad, after optional inversion
            assign drive_val[g] = (alt_out_sel[g] ? alt_val[g] : data_r[g])
                                  ^ cfg_r[g][`CFG_POL_BIT];
            always_comb begin
                if (cfg_r[g][`CFG_DIR_BIT]) begin
                    oe_pin  = 1'b0;
                    out_pin = 1'b0;
                end else if (cfg_r[g][`CFG_OTYPE_BIT]) begin
                    // open drain releases the pad for a high value
                    oe_pin  = ~drive_val[g];
                    out_pin = 1'b0;
                end else begin
                    oe_pin  = 1'b1;
                    out_pin = drive_val[g];
                end
            end

            // hand the per-pin decision to the registered pad vectors
            assign pad_oe_nxt[g]  = oe_pin;
            assign pad_out_nxt[g] = out_pin;
        end
    endgenerate

    // registered pad drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out_r <= 8'h00;
            pad_oe_r  <= 8'h00;
        end else begin
            pad_out_r <= pad_out_nxt;
            pad_oe_r  <= pad_oe_nxt;
        end
    end

    // infrared receive feed, held low while the pin is plain gpio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_rx_r <= 1'b0;
        end else if (cfg_r[`PIN_IR_RX][`CFG_FSEL_BIT]) begin
            ir_rx_r <= pin_level[`PIN_IR_RX];
        end else begin
            ir_rx_r <= 1'b0;
        end
    end

    // previous pin level, tracked always so selecting the interrupt sees no stale edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_level_prev_r <= 1'b0;
        end else begin
            irq_level_prev_r <= pin_level[`PIN_DENSITY_ONE];
        end
    end

    // either-edge interrupt: one pulse per level change; code 11 is inert
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_irq_r <= 1'b0;
        end else begin
            edge_irq_r <= (fsel_two == `FSEL2_EDGE_IRQ)
                          & (pin_level[`PIN_DENSITY_ONE] ^ irq_level_prev_r);
        end
    end

    // read data selection
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (hit_cfg) begin
            for (int i = 0; i < `NUM_PINS; i++) begin
                if (cfg_sel[i]) begin
                    prdata_nxt = {24'h00_0000, cfg_r[i]};
                end
            end
        end else if (hit_data) begin
            prdata_nxt = {24'h00_0000, data_r};
        end else if (hit_level) begin
            prdata_nxt = {24'h00_0000, pin_level};
        end
    end

    // apb ready: one wait state, then a single-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= access & ~pready_r;
        end
    end

    // apb error: raised with ready for a word that maps to nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= access & ~pready_r & ~(hit_cfg | hit_data | hit_level);
        end
    end

    // apb read data: loaded in the wait cycle and held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (access && !pready_r && !pwrite) begin
            prdata_r <= prdata_nxt;
        end
    end

    // all outputs straight from flip-flops
    assign prdata             = prdata_r;
    assign pready             = pready_r;
    assign pslverr            = pslverr_r;
    assign pad_out            = pad_out_r;
    assign pad_oe             = pad_oe_r;
    assign infrared_receive_b = ir_rx_r;
    assign edge_irq_b         = edge_irq_r;

endmodule : gpio_pin_config_group

`default_nettype wire

// ===== hdl/gpio_pin_config_consts.svh
`ifndef GPIO_PIN_CONFIG_CONSTS_SVH
`define GPIO_PIN_CONFIG_CONSTS_SVH

// number of pins served by this group
`define NUM_PINS          8

// configuration field positions
`define CFG_DIR_BIT       0
`define CFG_POL_BIT       1
`define CFG_FSEL_BIT      2
`define CFG_FSEL_HI_BIT   3
`define CFG_OTYPE_BIT     7

// writable bits: single-bit select and two-bit select layouts
`define CFG_MASK_ONE      8'h87
`define CFG_MASK_TWO      8'h8F

// register indices; byte address is four times the index
`define FAN_OUT_A_IDX     8'h36
`define IR_RECEIVE_B_IDX  8'h37
`define IR_TRANSMIT_B_IDX 8'h38
`define KBD_RESET_IDX     8'h39
`define GATE_A20_IDX      8'h3A
`define DENSITY_ZERO_IDX  8'h3B
`define DENSITY_ONE_IDX   8'h3C
`define POWER_EVENT_IDX   8'h3D
`define PIN_DATA_IDX      8'h48
`define PIN_LEVEL_IDX     8'h49

// pin positions within the pad vectors
`define PIN_FAN           0
`define PIN_IR_RX         1
`define PIN_IR_TX         2
`define PIN_KBD_RST       3
`define PIN_GATE_A20      4
`define PIN_DENSITY_ZERO  5
`define PIN_DENSITY_ONE   6
`define PIN_POWER_EVENT   7

// reset values
`define CFG_RST_DEFAULT   8'h01
`define FAN_OUT_A_RST_MAIN 8'h00
`define IR_RECEIVE_B_RST  8'h05
`define IR_TRANSMIT_B_RST 8'h04
`define PIN_DATA_RST      8'h00

// two-bit function select codes
`define FSEL2_GPIO        2'b00
`define FSEL2_DENSITY     2'b01
`define FSEL2_EDGE_IRQ    2'b10
`define FSEL2_RSVD        2'b11

`endif

// ===== hdl/gpio_pin_config_pkg.sv
package gpio_pin_config_pkg;

    // one pin configuration register
    typedef logic [7:0] cfg_t;

    // two-bit alternate function select
    typedef logic [1:0] fsel_t;

endpackage : gpio_pin_config_pkg

// ===== sim/gpio_pin_config_chk.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_config_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [7:0]        pad_in,
    input wire logic              edge_irq_b
);
    // address decode of the configuration and pin words
    function automatic logic in_cfg(input logic [ADDR_W-1:0] a);
        return (a >> 10) == '0 && a[9:2] >= 8'h36 && a[9:2] <= 8'h3D;
    endfunction : in_cfg
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return in_cfg(a) || ((a >> 10) == '0 && a[9:3] == 7'h24);
    endfunction : mapped

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // bus phases
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence

    one_wait_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
        else $error("answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable && $past(psel))
        else $error("pready outside an access");
    err_unmapped_a: assert property (pready |-> pslverr == !mapped(paddr))
        else $error("pslverr does not match decode");
    err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returns data");
    rsvd_zero_a: assert property (
        pready && !pwrite && in_cfg(paddr) |-> prdata[31:8] == 24'h0
        && prdata[6:4] == 3'h0 && (paddr[9:2] == 8'h3C || !prdata[3]))
        else $error("reserved bits read nonzero");
    rdata_hold_a: assert property (prdata != $past(prdata) |-> pready && !pwrite)
        else $error("read data changed without a read");
    edge_cause_a: assert property (edge_irq_b |->
        $past(pad_in[6], 2) != $past(pad_in[6], 3) || $past(pad_in[6], 3) != $past(pad_in[6], 4))
        else $error("edge pulse without a pad edge");
endmodule : gpio_pin_config_chk

bind gpio_pin_config_group gpio_pin_config_chk #(.ADDR_W(ADDR_W)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .edge_irq_b(edge_irq_b));
`default_nettype wire

// ===== sim/board_pads.sv
`timescale 1ns/1ns
`default_nettype none
module board_pads (
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pad_in
);
    // driven pads show the drive, released pads the board level or pull-up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule : board_pads
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        main_power_on_reset, pci_reset_n, infrared_receive_b, edge_irq_b;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  pad_in, pad_out, pad_oe, fn, ext_val;
    logic [7:0]  rst_v [8] = '{8'h01, 8'h05, 8'h04, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
    int          n_errors, checks_done, cnt;

    gpio_pin_config_group dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_power_on_reset(main_power_on_reset), .pci_reset_n(pci_reset_n),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .fan_speed_out_a(fn[0]),
        .infrared_transmit_b(fn[2]), .keyboard_reset_out_n(fn[3]), .gate_a20_out(fn[4]),
        .drive_density_sel_zero(fn[5]), .drive_density_sel_one(fn[6]),
        .power_event_out_n(fn[7]), .infrared_receive_b(infrared_receive_b),
        .edge_irq_b(edge_irq_b));
    board_pads board (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val), .pad_in(pad_in));

    // clock
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // one bus transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    function automatic logic [11:0] ca(input int p);
        return 12'((8'h36 + p) * 4);
    endfunction : ca

    // expected {oe, out} of an output pin
    function automatic logic [1:0] pad_exp(input logic [7:0] c, input logic v);
        logic x;
        x = v ^ c[1];
        return c[7] ? {~x, 1'h0} : {1'h1, x};
    endfunction : pad_exp

    task automatic t_regs;
        for (int i = 0; i < 8; i++) begin
            apb(1'h0, ca(i), 8'h0);
            chk(q, {24'h0, rst_v[i]}, "reset value");
            apb(1'h1, ca(i), 8'hFF);
            apb(1'h0, ca(i), 8'h0);
            chk(q, (i == 6) ? 32'h8F : 32'h87, "writable bits");
            apb(1'h1, ca(i), rst_v[i]);
        end
        apb(1'h0, 12'h100, 8'h0);
        chk(q, 32'h0, "unmapped read data");
        chk(e, 32'h1, "unmapped read error");
    endtask : t_regs

    task automatic t_gpio;
        logic [7:0] cs [4] = '{8'h00, 8'h02, 8'h80, 8'h82};
        for (int v = 0; v < 2; v++) begin
            apb(1'h1, 12'h120, 8'(v));
            apb(1'h0, 12'h120, 8'h0);
            chk(q, 32'(v), "pin data readback");
            foreach (cs[k]) begin
                apb(1'h1, ca(0), cs[k]);
                tick(2);
                chk({pad_oe[0], pad_out[0]}, pad_exp(cs[k], v[0]), "gpio pad");
            end
        end
        apb(1'h1, ca(0), 8'h01);
    endtask : t_gpio

    task automatic t_alt(input logic [7:0] c);
        for (int p = 0; p < 8; p++) begin
            if (p != 1) begin
                apb(1'h1, ca(p), c);
                for (int v = 0; v < 2; v++) begin
                    fn[p] <= v[0];
                    tick(2);
                    chk({pad_oe[p], pad_out[p]}, pad_exp(c, v[0]), "alt pad");
                end
                apb(1'h1, ca(p), 8'h01);
            end
        end
    endtask : t_alt

    task automatic t_irx(input logic [7:0] c);
        apb(1'h1, ca(1), c);
        for (int v = 0; v < 2; v++) begin
            ext_val[1] <= v[0];
            tick(4);
            chk(infrared_receive_b, c[2] & (v[0] ^ c[1]), "ir receive");
            apb(1'h0, 12'h124, 8'h0);
            chk(q[1], v[0] ^ c[1], "pin level");
        end
    endtask : t_irx

    task automatic t_irq(input logic [7:0] c);
        apb(1'h1, ca(6), c);
        tick(4);
        for (int k = 0; k < 2; k++) begin
            cnt = 0;
            ext_val[6] <= ~ext_val[6];
            repeat (6) begin
                @(posedge pclk);
                cnt += (edge_irq_b === 1'h1);
            end
            chk(cnt, (c[3:2] == 2'h2), "edge pulses");
        end
    endtask : t_irq

    task automatic t_por(input int k);
        apb(1'h1, ca(0), 8'h87);
        apb(1'h1, ca(2), 8'h00);
        apb(1'h1, ca(3), 8'h80);
        if (k == 0) main_power_on_reset <= 1'h1;
        else pci_reset_n <= 1'h0;
        tick(4);
        main_power_on_reset <= 1'h0;
        pci_reset_n <= 1'h1;
        tick(3);
        apb(1'h0, ca(0), 8'h0);
        chk(q, 32'h00, "main reset idx36");
        apb(1'h0, ca(2), 8'h0);
        chk(q, 32'h04, "main reset idx38");
        apb(1'h0, ca(3), 8'h0);
        chk(q, 32'h80, "main reset idx39");
    endtask : t_por

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, main_power_on_reset} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pci_reset_n = 1'h1;
        fn = 8'h00;
        ext_val = 8'hFF;
        tick(8);
        presetn <= 1'h1;
        chk(pad_oe, 8'h00, "pads released");
        t_regs();
        t_gpio();
        t_alt(8'h04);
        t_alt(8'h86);
        t_irx(8'h05);
        t_irx(8'h07);
        t_irx(8'h01);
        t_irq(8'h09);
        t_irq(8'h0D);
        t_irq(8'h05);
        t_por(0);
        t_por(1);
        end_of_test();
    end

    // watchdog
    initial begin
        tick(6000);
        n_errors++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
